// ### hw/rtcpc_pkg.sv
// ==========================================================
// Shared constants of the run and periodic control block
// ==========================================================
package rtcpc_pkg;

    // ======================================================
    // Register byte offsets
    // ======================================================
    localparam logic [11:0] OFS_CTRL      = 12'h000; // rtc_control_two
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h004; // Sticky events
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h008; // Event enables
    localparam logic [11:0] OFS_STATE     = 12'h00C; // Live state view

    // ======================================================
    // Control field positions
    // ======================================================
    localparam int BIT_FLAG   = 7;  // periodic_flag
    localparam int BIT_SEL_HI = 6;  // interval_sel_hi
    localparam int BIT_SEL_LO = 4;  // interval_sel_lo
    localparam int BIT_OSC    = 3;  // osc_run_enable
    localparam int BIT_ROUND  = 2;  // half_minute_round
    localparam int BIT_DIVRST = 1;  // Divider reset
    localparam int BIT_RUN    = 0;  // Counter run

    // ======================================================
    // Event bits of status and mask
    // ======================================================
    localparam int EVT_PERIOD = 0;  // Periodic interval elapsed
    localparam int EVT_SECOND = 1;  // Seconds tick issued
    localparam int EVT_ROUND  = 2;  // Rounding done
    localparam int EVT_W      = 3;  // Number of events

    // ======================================================
    // Reset values and figures
    // ======================================================
    localparam logic [7:0]       CTRL_POR     = 8'h09; // Osc and run set
    localparam logic [EVT_W-1:0] EVT_RST      = 3'h0;  // No pending events
    localparam logic [7:0]       SEC_ROUND_UP = 8'h30; // BCD 30 seconds
    localparam int               PRESC_W      = 7;     // 32768 Hz to 256 Hz
    localparam int               SUB_W        = 9;     // 256 Hz to 0.5 Hz

    typedef logic [2:0] rtcpc_sel_t;   // Interval selector code

    // Low sub-count bits that must wrap for an interval event
    function automatic logic [SUB_W-1:0] interval_mask(input rtcpc_sel_t sel);
        case (sel)
            3'h1:    interval_mask = 9'h000; // 1/256 s
            3'h2:    interval_mask = 9'h003; // 1/64 s
            3'h3:    interval_mask = 9'h00F; // 1/16 s
            3'h4:    interval_mask = 9'h03F; // 1/4 s
            3'h5:    interval_mask = 9'h07F; // 1/2 s
            3'h6:    interval_mask = 9'h0FF; // 1 s
            3'h7:    interval_mask = 9'h1FF; // 2 s
            default: interval_mask = 9'h1FF; // Unused, code 0 is off
        endcase
    endfunction

endpackage

// ### hw/rtcpc_div_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Divider chain carrier
// ==========================================================
interface rtcpc_div_if;
    import rtcpc_pkg::*;
    logic             tick;      // One pulse per 1/256 s
    logic [SUB_W-1:0] sub_cnt;   // Sub-second count after the tick
    logic             clear;     // Divider chain restart
    logic             osc_en;    // Oscillator run enable

    modport divider  (input clear, osc_en, output tick, sub_cnt);
    modport consumer (output clear, osc_en, input tick, sub_cnt);
endinterface
`default_nettype wire

// ### hw/rtcpc_divider.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Prescaler and sub-second counter
// ==========================================================
module rtcpc_divider (
    input  wire logic      clk_in,      // System clock
    input  wire logic      rst_in,      // Power-on reset
    input  wire logic      osc_pin_in,  // 32.768 kHz crystal pin
    rtcpc_div_if.divider   div          // Chain to the control logic
);
    import rtcpc_pkg::*;

    logic               sync1_q;   // First synchroniser stage
    logic               sync2_q;   // Second synchroniser stage
    logic               prev_q;    // Delayed copy for edge detect
    logic [PRESC_W-1:0] presc_q;   // Prescaler
    logic               tick_q;    // 256 Hz tick
    logic [SUB_W-1:0]   sub_q;     // Sub-second count
    logic               osc_edge;  // Rising crystal edge, enabled

    // Pin crossing; only the second stage is looked at
    always_ff @(posedge clk_in) begin
        sync1_q <= osc_pin_in;
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
    end

    // Halting the oscillator stops the whole chain
    assign osc_edge = div.osc_en & sync2_q & ~prev_q;

    // Prescaler counts crystal edges; one chain for all timing
    always_ff @(posedge clk_in) begin
        if (rst_in || div.clear) begin
            presc_q <= '0;
        end else if (osc_edge) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // Sub-second counter ignores the run bit
    always_ff @(posedge clk_in) begin
        if (rst_in || div.clear) begin
            tick_q <= 1'b0;
            sub_q  <= '0;
        end else begin
            tick_q <= osc_edge && (presc_q == 7'h7F);
            if (osc_edge && (presc_q == 7'h7F)) begin
                sub_q <= sub_q + 9'h001;
            end
        end
    end

    assign div.tick    = tick_q;
    assign div.sub_cnt = sub_q;
endmodule
`default_nettype wire

// ### hw/rtcpc_interval.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Periodic interval selector
// ==========================================================
module rtcpc_interval (
    input  wire logic                 clk_in,   // System clock
    input  wire logic                 rst_in,   // Power-on reset
    input  wire logic                 tick_in,  // 256 Hz tick
    input  wire logic [8:0]           sub_in,   // Sub-second count
    input  wire rtcpc_pkg::rtcpc_sel_t sel_in,  // Interval selector
    output logic                      evt_out   // One-cycle interval event
);
    import rtcpc_pkg::*;

    logic evt_q;  // Registered event

    // Event when masked low bits wrap to zero on a tick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= tick_in && (sel_in != 3'h0)
                     && ((sub_in & interval_mask(sel_in)) == 9'h000);
        end
    end

    assign evt_out = evt_q;

    a_evt_from_tick: assert property (@(posedge clk_in) disable iff (rst_in)
        evt_q |-> $past(tick_in) && ($past(sel_in) != 3'h0))
        else $error("interval event without tick or with selector off");
endmodule
`default_nettype wire

// ### hw/rtcpc_top.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Run and periodic control of the calendar clock
// ==========================================================
// How it works
// - Control resets to 09 at power-on
// - Manual reset spares oscillator and run bits
// - Standby drops control writes; interval elapse and manual reset still act
// - Interval elapse or written one sets flag
// - Writing zero clears the periodic flag
// - Flag set drives periodic interrupt request
// - Selector bits choose interval, zero disables
// - Oscillator enable halts or runs crystal
// - Rounding write clears seconds, maybe carries
// - Rounding resets divider, reads back zero
// - Divider reset clears chain, reads zero
// - Run bit gates second through year
// - Sub-second counter runs whenever oscillator runs
module rtcpc_top (
    input  wire logic        CLK_IN,           // 10 MHz system clock
    input  wire logic        RST_IN,           // Power-on reset, high
    input  wire logic        MRST_IN,          // Manual reset pin, high
    input  wire logic        STANDBY_IN,       // Standby request pin, high
    input  wire logic        OSC_PIN_IN,       // Crystal clock pin
    input  wire logic [7:0]  SECONDS_IN,       // BCD seconds count
    input  wire logic        PSEL_IN,          // APB select
    input  wire logic        PENABLE_IN,       // APB enable
    input  wire logic        PWRITE_IN,        // APB direction
    input  wire logic [11:0] PADDR_IN,         // APB byte address
    input  wire logic [31:0] PWDATA_IN,        // APB write data
    input  wire logic [3:0]  PSTRB_IN,         // APB byte strobes
    output logic [31:0]      PRDATA_OUT,       // APB read data
    output logic             PREADY_OUT,       // APB ready
    output logic             PSLVERR_OUT,      // APB error
    output logic             OSC_RUN_OUT,      // Crystal oscillator enable
    output logic             COUNT_RUN_OUT,    // Counters may count
    output logic             SEC_TICK_OUT,     // Seconds advance pulse
    output logic             SEC_CLEAR_OUT,    // Seconds to 00 pulse
    output logic             MIN_CARRY_OUT,    // Minute carry pulse
    output logic             PERIODIC_IRQ_OUT, // Periodic request level
    output logic             IRQ_OUT           // Masked event interrupt
);
    import rtcpc_pkg::*;

    // ======================================================
    // Declarations
    // ======================================================
    logic             mrst1_q;      // Manual reset stage 1
    logic             mrst2_q;      // Manual reset stage 2
    logic             stby1_q;      // Standby stage 1
    logic             stby2_q;      // Standby stage 2
    logic             flag_q;       // periodic_flag
    rtcpc_sel_t       sel_q;        // Interval selector
    logic             osc_q;        // osc_run_enable
    logic             run_q;        // Counter run
    logic             pready_q;     // Ready phase marker
    logic [31:0]      prdata_q;     // Captured read data
    logic             pslverr_q;    // Captured error
    logic             sec_tick_q;   // Gated seconds tick
    logic             sec_clr_q;    // Seconds clear pulse
    logic             min_car_q;    // Minute carry pulse
    logic [EVT_W-1:0] stat_q;       // Sticky event bits
    logic [EVT_W-1:0] mask_q;       // Event enables
    logic             irq_q;        // Interrupt level
    logic             period_evt;   // Interval elapsed
    logic             access;       // Access phase present
    logic             done;         // Transfer completes this edge
    logic             wr_ctrl;      // Control write takes effect
    logic             round_wr;     // Rounding requested
    logic             divrst_wr;    // Divider reset requested
    logic             sec_wrap;     // Whole second on the chain
    logic [EVT_W-1:0] evt_set;      // Event set terms
    logic [7:0]       ctrl_rd;      // Control read view

    rtcpc_div_if div_bus ();        // Divider chain carrier

    // ======================================================
    // Divider chain and interval selector
    // ======================================================
    rtcpc_divider u_div (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .osc_pin_in (OSC_PIN_IN),
        .div        (div_bus.divider)
    );

    rtcpc_interval u_int (
        .clk_in  (CLK_IN),
        .rst_in  (RST_IN),
        .tick_in (div_bus.tick),
        .sub_in  (div_bus.sub_cnt),
        .sel_in  (sel_q),
        .evt_out (period_evt)
    );

    assign div_bus.osc_en = osc_q;
    assign div_bus.clear  = round_wr | divrst_wr;
    assign sec_wrap       = div_bus.tick && (div_bus.sub_cnt[7:0] == 8'h00);

    // ======================================================
    // Pin synchronisers
    // ======================================================
    // Both pins are asynchronous; logic reads only stage 2
    always_ff @(posedge CLK_IN) begin
        mrst1_q <= MRST_IN;
        mrst2_q <= mrst1_q;
        stby1_q <= STANDBY_IN;
        stby2_q <= stby1_q;
    end

    // ======================================================
    // APB slave
    // ======================================================
    // One wait state gives a registered read path
    assign access = PSEL_IN && PENABLE_IN;
    assign done   = access && pready_q;

    // Writes to control are dropped in standby so selector, oscillator and run hold; flag still follows interval and manual reset
    assign wr_ctrl   = done && PWRITE_IN && PSTRB_IN[0]
                       && (PADDR_IN == OFS_CTRL) && !stby2_q;
    assign round_wr  = wr_ctrl && PWDATA_IN[BIT_ROUND];
    assign divrst_wr = wr_ctrl && PWDATA_IN[BIT_DIVRST];

    // Self-clearing bits always read as zero
    assign ctrl_rd = {flag_q, sel_q, osc_q, 1'b0, 1'b0, run_q};

    // Ready rises for the second access cycle only
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access && !pready_q;
        end
    end

    // Read data and error captured before ready rises
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pslverr_q <= 1'b0;
            case (PADDR_IN)
                OFS_CTRL:     prdata_q <= {24'h00_0000, ctrl_rd};
                OFS_IRQ_STAT: prdata_q <= {29'h0, stat_q};
                OFS_IRQ_MASK: prdata_q <= {29'h0, mask_q};
                OFS_STATE:    prdata_q <= {22'h0, stby2_q, run_q, 1'b0,
                                           div_bus.sub_cnt[7:1]};
                default: begin
                    // Unmapped address answers with an error
                    prdata_q  <= 32'h0000_0000;
                    pslverr_q <= 1'b1;
                end
            endcase
        end else if (!access) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // ======================================================
    // Control register
    // ======================================================
    // Flag: an elapsed interval wins over a written zero
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            flag_q <= CTRL_POR[BIT_FLAG];
        end else if (mrst2_q) begin
            flag_q <= CTRL_POR[BIT_FLAG];
        end else if (period_evt || (wr_ctrl && PWDATA_IN[BIT_FLAG])) begin
            flag_q <= 1'b1;
        end else if (wr_ctrl) begin
            flag_q <= 1'b0;
        end
    end

    // Selector is cleared by either reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || mrst2_q) begin
            sel_q <= CTRL_POR[BIT_SEL_HI:BIT_SEL_LO];
        end else if (wr_ctrl) begin
            sel_q <= PWDATA_IN[BIT_SEL_HI:BIT_SEL_LO];
        end
    end

    // Oscillator and run survive manual reset so time keeps going
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            osc_q <= CTRL_POR[BIT_OSC];
            run_q <= CTRL_POR[BIT_RUN];
        end else if (wr_ctrl && !mrst2_q) begin
            osc_q <= PWDATA_IN[BIT_OSC];
            run_q <= PWDATA_IN[BIT_RUN];
        end
    end

    // ======================================================
    // Counter controls
    // ======================================================
    // Counter writes are only safe once run is low; run is exported
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            sec_tick_q <= 1'b0;
            sec_clr_q  <= 1'b0;
            min_car_q  <= 1'b0;
        end else begin
            sec_tick_q <= run_q && sec_wrap;
            sec_clr_q  <= round_wr;
            min_car_q  <= round_wr && (SECONDS_IN >= SEC_ROUND_UP);
        end
    end

    // ======================================================
    // Interrupt status and mask
    // ======================================================
    assign evt_set = {round_wr, run_q && sec_wrap, period_evt};

    // Sticky bits; a new event beats a write-one clear
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            stat_q <= EVT_RST;
        end else if (done && PWRITE_IN && PSTRB_IN[0]
                     && (PADDR_IN == OFS_IRQ_STAT)) begin
            stat_q <= (stat_q & ~PWDATA_IN[EVT_W-1:0]) | evt_set;
        end else begin
            stat_q <= stat_q | evt_set;
        end
    end

    // Mask register of the same layout
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            mask_q <= EVT_RST;
        end else if (done && PWRITE_IN && PSTRB_IN[0]
                     && (PADDR_IN == OFS_IRQ_MASK)) begin
            mask_q <= PWDATA_IN[EVT_W-1:0];
        end
    end

    // Level output, one cycle behind the status
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // ======================================================
    // Outputs
    // ======================================================
    assign PRDATA_OUT       = prdata_q;
    assign PREADY_OUT       = pready_q;
    assign PSLVERR_OUT      = pslverr_q;
    assign OSC_RUN_OUT      = osc_q;
    assign COUNT_RUN_OUT    = run_q;
    assign SEC_TICK_OUT     = sec_tick_q;
    assign SEC_CLEAR_OUT    = sec_clr_q;
    assign MIN_CARRY_OUT    = min_car_q;
    assign PERIODIC_IRQ_OUT = flag_q;
    assign IRQ_OUT          = irq_q;

    // ======================================================
    // Assertions
    // ======================================================
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    a_por_value: assert property (@(posedge CLK_IN) disable iff (1'b0)
        RST_IN |=> (ctrl_rd == 8'h09))
        else $error("control not 09 after power-on reset");

    a_mrst_spares: assert property (
        mrst2_q |=> (osc_q == $past(osc_q)) && (run_q == $past(run_q))
                    && (sel_q == 3'h0) && !flag_q)
        else $error("manual reset changed osc or run or missed a field");

    a_standby_hold: assert property (
        stby2_q && !mrst2_q |=> $stable(sel_q) && $stable(osc_q) && $stable(run_q))
        else $error("control changed during standby");

    a_flag_set: assert property (
        period_evt && !mrst2_q |=> flag_q [*1] ##0 PERIODIC_IRQ_OUT)
        else $error("interval elapsed but flag not set");

    a_flag_clear: assert property (
        wr_ctrl && !PWDATA_IN[BIT_FLAG] && !period_evt |=> !PERIODIC_IRQ_OUT)
        else $error("written zero did not clear flag");

    a_flag_holds: assert property (
        flag_q && !mrst2_q && !wr_ctrl |=> PERIODIC_IRQ_OUT)
        else $error("periodic request dropped without a clear");

    a_osc_halt: assert property (
        !osc_q && !div_bus.clear |=> $stable(div_bus.sub_cnt))
        else $error("chain moved with oscillator halted");

    a_round_carry: assert property (
        round_wr |=> SEC_CLEAR_OUT && (MIN_CARRY_OUT == ($past(SECONDS_IN) >= 8'h30)))
        else $error("rounding clear or carry wrong");

    a_div_restart: assert property (
        div_bus.clear |=> (div_bus.sub_cnt == 9'h000) ##1 !div_bus.tick)
        else $error("divider not restarted");

    a_run_gate: assert property (
        !run_q |=> !SEC_TICK_OUT)
        else $error("seconds tick while stopped");

    c_period_evt: cover property (period_evt && (sel_q == 3'h1));
    c_round_up: cover property (round_wr && (SECONDS_IN >= SEC_ROUND_UP));
    c_mrst: cover property (mrst2_q && !osc_q);
    c_irq: cover property (IRQ_OUT && PERIODIC_IRQ_OUT);
endmodule
`default_nettype wire

// ### tb/rtcpc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench of the run and periodic control block
// ==========================================================
module rtcpc_top_tb_top;
    import rtcpc_pkg::*;
    logic        clk = 1'b0;      // System clock
    logic        rst = 1'b1;      // Power-on reset
    logic        mrst = 1'b0;     // Manual reset pin
    logic        stby = 1'b0;     // Standby pin
    logic        osc = 1'b0;      // Fast stand-in crystal
    logic [7:0]  secs = 8'h00;    // Seconds seen by the block
    logic        psel = 1'b0;     // Bus select
    logic        pen = 1'b0;      // Bus enable
    logic        pwr = 1'b0;      // Bus direction
    logic [11:0] padr = 12'h000;  // Bus address
    logic [31:0] pwd = 32'h0;     // Bus write data
    logic [31:0] prd;             // Bus read data
    logic [31:0] rdat;            // Data taken at completion
    logic [31:0] s1;              // Saved state view
    logic        rdy, serr, rerr, orun, crun, sclr, mcar, pirq, irq, stk;
    int          bad_count = 0;   // Mismatches
    int          checked = 0;     // Comparisons
    int          cyc = 0;         // Cycles run
    int          nclr = 0;        // Seconds clear pulses
    int          ncar = 0;        // Minute carry pulses
    int          nsec = 0;        // Seconds tick pulses
    int          ohalf = 2;       // Crystal half period in cycles
    logic [7:0]  mr [2] = '{8'hD0, 8'hD9}; // Osc and run both ways

    rtcpc_top dut (.CLK_IN(clk), .RST_IN(rst), .MRST_IN(mrst), .STANDBY_IN(stby),
        .OSC_PIN_IN(osc), .SECONDS_IN(secs), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PSTRB_IN(4'hF),
        .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(serr), .OSC_RUN_OUT(orun),
        .COUNT_RUN_OUT(crun), .SEC_TICK_OUT(stk), .SEC_CLEAR_OUT(sclr),
        .MIN_CARRY_OUT(mcar), .PERIODIC_IRQ_OUT(pirq), .IRQ_OUT(irq));

    // ======================================================
    // Clocks, pulse counters and hang guard
    // ======================================================
    initial forever #50 clk = ~clk;
    // Crystal far faster than real: a tick is 512 cycles, 256 once sped up
    always begin
        repeat (ohalf) @(posedge clk);
        osc <= ~osc;
    end
    // One-cycle pulses are counted, so no check can miss them
    always @(posedge clk) begin
        cyc++;
        if (sclr === 1'b1) nclr++;
        if (mcar === 1'b1) ncar++;
        if (stk === 1'b1) nsec++;
        if (cyc == 90000) begin
            bad_count++;
            results();
        end
    end

    // ======================================================
    // Tasks
    // ======================================================
    task results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task pin(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // One transfer; request held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rdat = prd;
        rerr = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    // ======================================================
    // Test sequence
    // ======================================================
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_CTRL, 32'h09, "control");
        pin("osc run", 1'b1, orun);
        pin("count run", 1'b1, crun);
        apb(1'b0, 12'h010, 32'h0);
        pin("slverr", 1'b1, rerr);
        chk("unmapped", 32'h0, rdat);
        apb(1'b1, OFS_CTRL, 32'h89);
        rdc(OFS_CTRL, 32'h89, "control");
        pin("periodic irq", 1'b1, pirq);
        apb(1'b1, OFS_CTRL, 32'h09);
        rdc(OFS_CTRL, 32'h09, "control");
        pin("periodic irq", 1'b0, pirq);
        // Rounding below and at half a minute
        apb(1'b1, OFS_IRQ_MASK, 32'h4);
        secs <= 8'h29;
        apb(1'b1, OFS_CTRL, 32'h0D);
        rdc(OFS_CTRL, 32'h09, "control");
        chk("clear pulses", 32'd1, nclr);
        chk("carry pulses", 32'd0, ncar);
        pin("irq", 1'b1, irq);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        rdc(OFS_IRQ_STAT, 32'h0, "status");
        pin("irq", 1'b0, irq);
        secs <= 8'h30;
        apb(1'b1, OFS_CTRL, 32'h0D);
        apb(1'b1, OFS_CTRL, 32'h0B);
        rdc(OFS_CTRL, 32'h09, "control");
        chk("carry pulses", 32'd1, ncar);
        chk("clear pulses", 32'd2, nclr);
        // Intervals: every tick, off, then four ticks after a chain restart
        apb(1'b1, OFS_CTRL, 32'h19);
        repeat (1200) @(posedge clk);
        pin("periodic irq", 1'b1, pirq);
        apb(1'b1, OFS_CTRL, 32'h09);
        repeat (1200) @(posedge clk);
        pin("periodic irq", 1'b0, pirq);
        apb(1'b1, OFS_CTRL, 32'h2B);
        repeat (1300) @(posedge clk);
        pin("periodic irq", 1'b0, pirq);
        repeat (1300) @(posedge clk);
        pin("periodic irq", 1'b1, pirq);
        // Oscillator off freezes the sub-second count
        apb(1'b1, OFS_CTRL, 32'h10);
        apb(1'b0, OFS_STATE, 32'h0);
        s1 = rdat;
        pin("osc run", 1'b0, orun);
        pin("count run", 1'b0, crun);
        pin("state run", 1'b0, s1[8]);
        repeat (1200) @(posedge clk);
        pin("periodic irq", 1'b0, pirq);
        rdc(OFS_STATE, s1, "state");
        // Oscillator on with run off: the chain still times intervals
        apb(1'b1, OFS_CTRL, 32'h18);
        repeat (1200) @(posedge clk);
        pin("periodic irq", 1'b1, pirq);
        foreach (mr[i]) begin
            apb(1'b1, OFS_CTRL, {24'h0, mr[i]});
            mrst <= 1'b1;
            repeat (6) @(posedge clk);
            mrst <= 1'b0;
            repeat (4) @(posedge clk);
            rdc(OFS_CTRL, {24'h0, mr[i] & 8'h09}, "control");
        end
        stby <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, OFS_CTRL, 32'h80);
        rdc(OFS_CTRL, 32'h09, "control");
        stby <= 1'b0;
        // Faster crystal so one whole second fits the run; 1 s interval
        ohalf = 1;
        apb(1'b1, OFS_CTRL, 32'h6B);
        repeat (60000) @(posedge clk);
        pin("periodic irq", 1'b0, pirq);
        repeat (6000) @(posedge clk);
        chk("second ticks", 32'd1, nsec);
        pin("periodic irq", 1'b1, pirq);
        rdc(OFS_IRQ_STAT, 32'h7, "status");
        results();
    end
endmodule
`default_nettype wire
